// >>> design/rxm_top.sv
/*
 * Receive MAC application side: media inputs in, bytes and end of frame to
 * an external receive FIFO, a per-frame statistics vector with its strobe,
 * and an AXI4-Lite register slave with a level interrupt.
 * Assumes aclk is the PHY receive clock and the FIFO reports each frame end
 * that leaves it.
 */
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "rxm_defines.svh"

// How it works
// - four-bit option: error sampled on both edges, then pipelined.
// - byte-wide options take one unsplit error input.
// - byte-wide data counts only while data valid is high.
// - collision used only in half-duplex 10/100 of four-bit and serial options.
// - carrier sense means activity; used under the same conditions as collision.
// - write request asks the FIFO to take the presented byte.
// - each received byte is presented on the eight-bit data output.
// - vector bits 15 to 0 hold the frame byte count.
// - bits 16 to 19: VLAN, pause, control frame, unsupported opcode.
// - bits 20 to 23: dribble nibble, broadcast, multicast, received correctly.
// - bits 24 to 27: length error, CRC error, ignored, earlier carrier event.
// - bit 28 unused; 29 gap violation, 30 short frame, 31 long frame.
// - strobe marks the vector valid; the receiver samples only under it.
// - full during a write raises the FIFO error, blocks writes until frame end leaves.
// - end of frame is raised once all frame data has gone to the FIFO.
// - 10/100 runs at half the receive clock; gigabit at the full clock.
module rxm_top import rxm_pkg::*; #(
	parameter int IPG_MIN = `RXM_IPG_MIN
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// media side
	input wire logic [7:0] rxd,
	input wire logic rxdv,
	input wire logic rxer,
	input wire logic [3:0] rxd_pos,
	input wire logic [3:0] rxd_neg,
	input wire logic rxdv_pos,
	input wire logic rxdv_neg,
	input wire logic rxer_pos,
	input wire logic rxer_neg,
	input wire logic col,
	input wire logic crs,
	// receive FIFO side
	input wire logic rx_fifo_full,
	input wire logic rx_fifo_eof_read,
	output logic rx_write,
	output logic [7:0] rx_dbout,
	output logic rx_eof,
	output logic rx_fifo_error,
	output logic [31:0] rx_stat_vector,
	output logic rx_stat_en,
	// interrupt
	output logic irq
);
	if (IPG_MIN < 1 || IPG_MIN > 31) begin : g_chk
		$error("IPG_MIN must lie in 1..31");
	end

	rxm_top_st_t q, d;
	rxm_frm_if frm ();
	rxm_opt_t opt;
	logic act, tick, sof, beat, full_hit;
	logic [7:0] cap_byte;
	logic cap_dv, cap_er, cap_half;
	logic [3:0] ev, clr;
	logic [31:0] m_ctrl, m_en;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	rxm_phy_capture u_cap (
		.aclk(aclk),
		.aresetn(aresetn),
		.four_bit(opt == opt_four_bit),
		.rxd(rxd),
		.rxdv(rxdv),
		.rxer(rxer),
		.rxd_pos(rxd_pos),
		.rxd_neg(rxd_neg),
		.rxdv_pos(rxdv_pos),
		.rxdv_neg(rxdv_neg),
		.rxer_pos(rxer_pos),
		.rxer_neg(rxer_neg),
		.byte_o(cap_byte),
		.dv_o(cap_dv),
		.er_o(cap_er),
		.half_o(cap_half)
	);

	rxm_stat_build u_stat (
		.aclk(aclk),
		.aresetn(aresetn),
		.frm(frm.dst)
	);

	assign frm.start = q.start;
	assign frm.beat = q.beat;
	assign frm.done = q.done;
	assign frm.data = q.bdata;

	// ----------------------------------------
	// frame qualifiers
	// ----------------------------------------
	assign opt = rxm_opt_t'(q.ctrl[`RXM_CTRL_OPT_HI:`RXM_CTRL_OPT_LO]);
	assign act = q.ctrl[`RXM_CTRL_HALF] && q.ctrl[`RXM_CTRL_SLOW] && opt != opt_gig;
	// half-rate tick stands in for the divided MAC clock, keeping one domain
	assign tick = !q.ctrl[`RXM_CTRL_SLOW] || q.phase;
	assign sof = tick && cap_dv && cap_byte == `RXM_SFD
		&& ((q.fst == st_idle && q.ctrl[`RXM_CTRL_EN]) || q.fst == st_pre);
	assign beat = tick && q.fst == st_data && cap_dv;
	assign full_hit = q.wr && rx_fifo_full;

	always_comb begin
		d = q;
		d.start = 1'b0;
		d.beat = 1'b0;
		d.done = 1'b0;
		d.wr = 1'b0;
		d.eof = 1'b0;
		d.vec_en = 1'b0;
		clr = 4'h0;
		ev = 4'h0;
		m_ctrl = merge({27'h0, q.ctrl}, q.w_data, q.w_strb);
		m_en = merge({28'h0, q.irq_en}, q.w_data, q.w_strb);

		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (s_axi_awvalid && q.awready) begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.aw_full && q.w_full && !q.bvalid) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `RXM_RESP_OKAY;
			case (q.aw_addr)
				`RXM_ADDR_CTRL: d.ctrl = m_ctrl[4:0];
				`RXM_ADDR_IRQ_EN: d.irq_en = m_en[3:0];
				`RXM_ADDR_IRQ_CLR: clr = q.w_strb[0] ? q.w_data[3:0] : 4'h0;
				`RXM_ADDR_STATUS, `RXM_ADDR_IRQ_STAT, `RXM_ADDR_LAST_VEC: ;
				default: d.bresp = `RXM_RESP_SLVERR;
			endcase
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		d.awready = !d.aw_full && !d.bvalid;
		d.wready = !d.w_full && !d.bvalid;

		// ----------------------------------------
		// register reads
		// ----------------------------------------
		if (s_axi_arvalid && q.arready) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = `RXM_RESP_OKAY;
			case (s_axi_araddr)
				`RXM_ADDR_CTRL: d.rdata = {27'h0, q.ctrl};
				`RXM_ADDR_STATUS: d.rdata = {28'h0, q.fst == st_data, q.fifo_err,
					q.col_seen, q.crs_seen};
				`RXM_ADDR_IRQ_STAT: d.rdata = {28'h0, q.irq_stat};
				`RXM_ADDR_IRQ_EN: d.rdata = {28'h0, q.irq_en};
				`RXM_ADDR_IRQ_CLR: d.rdata = 32'h0000_0000;
				`RXM_ADDR_LAST_VEC: d.rdata = q.vec;
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = `RXM_RESP_SLVERR;
				end
			endcase
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end

		// ----------------------------------------
		// half-duplex sensing
		// ----------------------------------------
		d.phase = q.ctrl[`RXM_CTRL_SLOW] ? !q.phase : 1'b0;
		d.crs_seen = act && crs;
		d.col_seen = act && col;
		ev[`RXM_IRQ_COL] = act && col && !q.col_seen;
		if (act && crs && q.fst == st_idle && !cap_dv)
			d.car_seen = 1'b1;

		// ----------------------------------------
		// frame sequencing
		// ----------------------------------------
		if (tick && q.fst != st_data && !cap_dv && q.ipg_cnt != 5'h1F)
			d.ipg_cnt = q.ipg_cnt + 5'h01;
		if (sof) begin
			d.fst = st_data;
			d.start = 1'b1;
			d.f_er = 1'b0;
			d.f_drop = 1'b0;
			d.f_half = 1'b0;
			d.f_car = q.car_seen;
			d.car_seen = 1'b0;
			d.f_ipg = q.seen_frame && q.ipg_cnt < IPG_MIN[4:0];
		end else if (tick) begin
			unique case (q.fst)
				st_idle: begin
					if (cap_dv && q.ctrl[`RXM_CTRL_EN])
						d.fst = st_pre;
				end
				st_pre: begin
					if (!cap_dv)
						d.fst = st_idle;
				end
				st_data: begin
					if (cap_dv) begin
						d.beat = 1'b1;
						d.bdata = cap_byte;
						d.f_er = q.f_er || cap_er;
						d.f_half = q.f_half || cap_half;
					end else begin
						d.fst = st_idle;
						d.done = 1'b1;
						d.eof = 1'b1;
						d.seen_frame = 1'b1;
						d.ipg_cnt = 5'h00;
					end
				end
			endcase
		end

		// ----------------------------------------
		// FIFO writes and overflow
		// ----------------------------------------
		// a full seen on a request wins over the frame-end clear
		d.fifo_err = (q.fifo_err && !(rx_fifo_eof_read && q.eof_pend)) || full_hit;
		ev[`RXM_IRQ_FIFO] = full_hit && !q.fifo_err;
		d.wr = beat && !d.fifo_err;
		if (beat)
			d.dbout = cap_byte;
		if (full_hit || (beat && d.fifo_err))
			d.f_drop = 1'b1;
		if (!d.fifo_err)
			d.eof_pend = 1'b0;
		else if (d.eof)
			d.eof_pend = 1'b1;

		// ----------------------------------------
		// statistics vector
		// ----------------------------------------
		if (frm.vld) begin
			d.vec = frm.vec;
			d.vec[`RXM_SV_DRIBBLE] = q.f_half;
			d.vec[`RXM_SV_OK] = frm.vec[`RXM_SV_OK] && !q.f_er && !q.f_drop;
			d.vec[`RXM_SV_IGNORED] = q.f_drop;
			d.vec[`RXM_SV_CARRIER] = q.f_car;
			d.vec[`RXM_SV_UNUSED] = 1'b0;
			d.vec[`RXM_SV_IPG] = q.f_ipg;
			d.vec_en = 1'b1;
			ev[`RXM_IRQ_FRAME_OK] = d.vec[`RXM_SV_OK];
			ev[`RXM_IRQ_FRAME_BAD] = !d.vec[`RXM_SV_OK];
		end

		// ----------------------------------------
		// interrupt
		// ----------------------------------------
		d.irq_stat = (q.irq_stat & ~clr) | ev;
		d.irq = |(d.irq_stat & d.irq_en);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.ctrl <= `RXM_CTRL_RESET;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
	assign rx_write = q.wr;
	assign rx_dbout = q.dbout;
	assign rx_eof = q.eof;
	assign rx_fifo_error = q.fifo_err;
	assign rx_stat_vector = q.vec;
	assign rx_stat_en = q.vec_en;
	assign irq = q.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	unused_bit_a: assert property (rx_stat_en |-> !rx_stat_vector[`RXM_SV_UNUSED])
		else $error("vector bit 28 not zero");
	stat_strobe_a: assert property (rx_stat_en |=> !rx_stat_en)
		else $error("statistics strobe longer than one cycle");
	fifo_hold_a: assert property (rx_fifo_error |-> !rx_write)
		else $error("write requested during FIFO error");
	fifo_set_a: assert property (rx_write && rx_fifo_full |=> rx_fifo_error)
		else $error("full on write did not raise FIFO error");
	eof_stat_a: assert property (rx_eof |-> !rx_write ##2 rx_stat_en)
		else $error("vector did not follow end of frame");
	col_gate_a: assert property (!act |=> !q.col_seen)
		else $error("collision used outside half-duplex 10/100");
	crs_gate_a: assert property (!act |=> !q.crs_seen)
		else $error("carrier sense used outside half-duplex 10/100");
	write_byte_a: assert property (beat && !d.fifo_err |=> rx_write && rx_dbout == $past(cap_byte))
		else $error("received byte not presented to FIFO");
	irq_level_a: assert property (irq == |(q.irq_stat & q.irq_en))
		else $error("interrupt level disagrees with status");
	slow_rate_a: assert property (q.ctrl[`RXM_CTRL_SLOW] && rx_write ##1 q.ctrl[`RXM_CTRL_SLOW] |-> !rx_write)
		else $error("10/100 writes faster than half rate");
endmodule

// >>> design/rxm_defines.svh
/*
 * Offsets, field positions, reset values and frame constants of the receive
 * MAC interface. Included by the top, capture and statistics files; holds definitions only.
 */
`ifndef RXM_DEFINES_SVH
`define RXM_DEFINES_SVH

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define RXM_ADDR_CTRL 8'h00
`define RXM_ADDR_STATUS 8'h04
`define RXM_ADDR_IRQ_STAT 8'h08
`define RXM_ADDR_IRQ_EN 8'h0C
`define RXM_ADDR_IRQ_CLR 8'h10
`define RXM_ADDR_LAST_VEC 8'h14
`define RXM_CTRL_RESET 5'h01
`define RXM_CTRL_EN 0
`define RXM_CTRL_OPT_HI 2
`define RXM_CTRL_OPT_LO 1
`define RXM_CTRL_SLOW 3
`define RXM_CTRL_HALF 4
`define RXM_IRQ_FRAME_OK 0
`define RXM_IRQ_FRAME_BAD 1
`define RXM_IRQ_FIFO 2
`define RXM_IRQ_COL 3
`define RXM_RESP_OKAY 2'h0
`define RXM_RESP_SLVERR 2'h2

// ----------------------------------------
// statistics vector bits
// ----------------------------------------
`define RXM_SV_VLAN 16
`define RXM_SV_PAUSE 17
`define RXM_SV_CTRL 18
`define RXM_SV_UNSUP 19
`define RXM_SV_DRIBBLE 20
`define RXM_SV_BCAST 21
`define RXM_SV_MCAST 22
`define RXM_SV_OK 23
`define RXM_SV_LEN_ERR 24
`define RXM_SV_CRC_ERR 25
`define RXM_SV_IGNORED 26
`define RXM_SV_CARRIER 27
`define RXM_SV_UNUSED 28
`define RXM_SV_IPG 29
`define RXM_SV_SHORT 30
`define RXM_SV_LONG 31

// ----------------------------------------
// frame constants
// ----------------------------------------
`define RXM_SFD 8'hD5
`define RXM_IPG_MIN 12
`define RXM_MIN_FRAME 16'h0040
`define RXM_MAX_FRAME 16'h05EE
`define RXM_MAX_VLAN 16'h05F2
`define RXM_MAX_LEN 16'h05DC
`define RXM_HDR_FCS 16'h0012
`define RXM_TYPE_VLAN 16'h8100
`define RXM_TYPE_CTRL 16'h8808
`define RXM_OPC_PAUSE 16'h0001
`define RXM_PAUSE_DA 48'h0180C2000001
`define RXM_CRC_INIT 32'hFFFFFFFF
`define RXM_CRC_POLY 32'hEDB88320
`define RXM_CRC_RESIDUE 32'hDEBB20E3

`endif

// >>> design/rxm_pkg.sv
/*
 * Types of the receive MAC interface: option and state enumerations and the
 * state records of each module. Assumes nothing of its surroundings.
 */
package rxm_pkg;
	typedef enum logic [1:0] {opt_four_bit, opt_gig, opt_sgmii} rxm_opt_t;
	typedef enum logic [1:0] {st_idle, st_pre, st_data} rxm_fst_t;

	typedef struct packed {
		logic [7:0] d;
		logic dv;
		logic er;
		logic [7:0] byte_o;
		logic dv_o;
		logic er_o;
		logic half_o;
	} rxm_cap_st_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [31:0] crc;
		logic [47:0] da;
		logic [15:0] typ;
		logic [15:0] opc;
		logic [31:0] vec;
		logic vld;
	} rxm_sb_st_t;

	typedef struct packed {
		logic awready, wready, arready, bvalid, rvalid;
		logic aw_full, w_full;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		logic [4:0] ctrl;
		logic [3:0] irq_stat, irq_en;
		logic irq, phase;
		rxm_fst_t fst;
		logic [4:0] ipg_cnt;
		logic seen_frame, car_seen, col_seen, crs_seen;
		logic f_er, f_drop, f_half, f_car, f_ipg;
		logic wr;
		logic [7:0] dbout;
		logic eof, fifo_err, eof_pend;
		logic [31:0] vec;
		logic vec_en;
		logic start, beat, done;
		logic [7:0] bdata;
	} rxm_top_st_t;
endpackage

// >>> design/rxm_frm_if.sv
/*
 * Byte stream of one received frame towards the statistics builder and the
 * finished partial vector back. Both ends run on the same clock.
 */
`timescale 1ns/10ps
interface rxm_frm_if;
	logic start;
	logic beat;
	logic done;
	logic [7:0] data;
	logic [31:0] vec;
	logic vld;
	modport src (output start, beat, done, data, input vec, vld);
	modport dst (input start, beat, done, data, output vec, vld);
endinterface

// >>> design/rxm_phy_capture.sv
/*
 * Input stage of the media side: four-bit split samples or the byte-wide
 * interface, pipelined into one byte, valid and error per cycle.
 * Assumes aclk is the receive MAC clock and the option stays still.
 */
`timescale 1ns/10ps
`include "rxm_defines.svh"
module rxm_phy_capture import rxm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// option
	input wire logic four_bit,
	// byte-wide media side
	input wire logic [7:0] rxd,
	input wire logic rxdv,
	input wire logic rxer,
	// four-bit media side
	input wire logic [3:0] rxd_pos,
	input wire logic [3:0] rxd_neg,
	input wire logic rxdv_pos,
	input wire logic rxdv_neg,
	input wire logic rxer_pos,
	input wire logic rxer_neg,
	// captured stream
	output logic [7:0] byte_o,
	output logic dv_o,
	output logic er_o,
	output logic half_o
);
	rxm_cap_st_t q, d;
	// falling-edge copy lives apart: it is the only state on the other edge
	logic [5:0] neg_q;

	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			neg_q <= 6'h00;
		end else begin
			neg_q <= {rxd_neg, rxdv_neg, rxer_neg};
		end
	end

	always_comb begin
		d = q;
		if (four_bit) begin
			d.d = {4'h0, rxd_pos};
			d.dv = rxdv_pos;
			d.er = rxer_pos;
			d.byte_o = {q.d[3:0], neg_q[5:2]};
			d.dv_o = q.dv | neg_q[1];
			d.er_o = q.er | neg_q[0];
			d.half_o = q.dv ^ neg_q[1];
		end else begin
			d.d = rxd;
			d.dv = rxdv;
			d.er = rxer;
			d.byte_o = q.dv ? q.d : 8'h00;
			d.dv_o = q.dv;
			d.er_o = q.er;
			d.half_o = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign byte_o = q.byte_o;
	assign dv_o = q.dv_o;
	assign er_o = q.er_o;
	assign half_o = q.half_o;

	split_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(four_bit && rxer_pos) ##1 four_bit |=> er_o)
		else $error("rising error sample not passed on");
	gmii_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!four_bit && rxer) ##1 !four_bit |=> er_o)
		else $error("byte-wide error not passed on");
	gmii_dv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!four_bit && !rxdv) ##1 !four_bit |=> !dv_o && byte_o == 8'h00)
		else $error("data used without valid");
endmodule

// >>> design/rxm_stat_build.sv
/*
 * Per-frame statistics: byte count, address class, type and opcode
 * decode, CRC and length checks. Fed byte by byte after the start delimiter.
 */
`timescale 1ns/10ps
`include "rxm_defines.svh"
module rxm_stat_build import rxm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// frame stream
	rxm_frm_if.dst frm
);
	rxm_sb_st_t q, d;
	logic [15:0] long_lim;
	logic is_ctrl;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ `RXM_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	always_comb begin
		d = q;
		d.vld = 1'b0;
		long_lim = (q.typ == `RXM_TYPE_VLAN) ? `RXM_MAX_VLAN : `RXM_MAX_FRAME;
		is_ctrl = q.typ == `RXM_TYPE_CTRL;
		if (frm.start) begin
			d.cnt = 16'h0000;
			d.crc = `RXM_CRC_INIT;
			d.da = 48'h0;
			d.typ = 16'h0000;
			d.opc = 16'h0000;
		end else if (frm.beat) begin
			d.cnt = q.cnt + 16'h0001;
			d.crc = crc_byte(q.crc, frm.data);
			if (q.cnt < 16'h0006)
				d.da = {q.da[39:0], frm.data};
			if (q.cnt == 16'h000C || q.cnt == 16'h000D)
				d.typ = {q.typ[7:0], frm.data};
			if (q.cnt == 16'h000E || q.cnt == 16'h000F)
				d.opc = {q.opc[7:0], frm.data};
		end
		if (frm.done) begin
			d.vld = 1'b1;
			d.vec = 32'h0000_0000;
			d.vec[15:0] = q.cnt;
			d.vec[`RXM_SV_VLAN] = q.typ == `RXM_TYPE_VLAN;
			d.vec[`RXM_SV_PAUSE] = is_ctrl && q.opc == `RXM_OPC_PAUSE
				&& q.da == `RXM_PAUSE_DA;
			d.vec[`RXM_SV_CTRL] = is_ctrl;
			d.vec[`RXM_SV_UNSUP] = is_ctrl && q.opc != `RXM_OPC_PAUSE;
			d.vec[`RXM_SV_BCAST] = &q.da;
			d.vec[`RXM_SV_MCAST] = q.da[40] && !(&q.da);
			d.vec[`RXM_SV_LEN_ERR] = q.typ <= `RXM_MAX_LEN
				&& q.cnt < q.typ + `RXM_HDR_FCS;
			d.vec[`RXM_SV_CRC_ERR] = q.crc != `RXM_CRC_RESIDUE;
			d.vec[`RXM_SV_SHORT] = q.cnt < `RXM_MIN_FRAME;
			d.vec[`RXM_SV_LONG] = q.cnt > long_lim;
			// clean here; the top also folds in media errors and drops
			d.vec[`RXM_SV_OK] = !(d.vec[`RXM_SV_LEN_ERR] || d.vec[`RXM_SV_CRC_ERR]
				|| d.vec[`RXM_SV_SHORT] || d.vec[`RXM_SV_LONG]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign frm.vec = q.vec;
	assign frm.vld = q.vld;

	class_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
		frm.done |=> frm.vld && !(frm.vec[`RXM_SV_BCAST] && frm.vec[`RXM_SV_MCAST]))
		else $error("vector missing or address class not exclusive");
endmodule

// >>> sim/rxm_phy_model.sv
/*
 * Far side of the receive MAC: a media source driving both the byte-wide and
 * the split four-bit inputs, and a receive FIFO that stores written bytes.
 * Assumes the block samples the media inputs on aclk.
 */
`timescale 1ns/10ps
module rxm_phy_model (
	// clock
	input wire logic aclk,
	// media side
	output logic [7:0] rxd,
	output logic rxdv,
	output logic rxer,
	output logic [3:0] rxd_pos,
	output logic [3:0] rxd_neg,
	output logic rxdv_pos,
	output logic rxdv_neg,
	output logic rxer_pos,
	output logic rxer_neg,
	// receive fifo side
	output logic rx_fifo_full,
	output logic rx_fifo_eof_read,
	input wire logic rx_write,
	input wire logic [7:0] rx_dbout,
	input wire logic rx_eof
);
	int hold = 1;
	int cap = 100000;
	int err_at = -1;
	logic [7:0] got[$];
	logic [3:0] eofd;
	logic [5:0] neg_d;

	// ----------------------------------------
	// media source
	// ----------------------------------------
	initial begin
		rxd = 8'h00;
		rxdv = 1'b0;
		rxer = 1'b0;
		rx_fifo_full = 1'b0;
		rx_fifo_eof_read = 1'b0;
		eofd = 4'h0;
		neg_d = 6'h00;
	end
	// high nibble on the rising sample; the low half trails by one clock
	// so the falling sample after that edge still sees the same byte
	assign rxd_pos = rxd[7:4];
	assign rxd_neg = neg_d[5:2];
	assign rxdv_pos = rxdv;
	assign rxdv_neg = neg_d[1];
	assign rxer_pos = rxer;
	assign rxer_neg = neg_d[0];

	task automatic send(input logic [7:0] f[$]);
		logic [7:0] s[$];
		s = {8'h55, 8'h55, 8'h55, 8'hD5, f};
		foreach (s[i]) begin
			repeat (hold) @(posedge aclk);
			rxdv <= 1'b1;
			rxd <= s[i];
			rxer <= i == err_at;
		end
		repeat (hold) @(posedge aclk);
		rxdv <= 1'b0;
		rxer <= 1'b0;
		// released data must not look like the last byte
		rxd <= ~rxd;
	endtask

	// ----------------------------------------
	// receive fifo
	// ----------------------------------------
	always @(posedge aclk) begin
		// a write while full is lost, as in a real fifo
		if (rx_write && !rx_fifo_full) got.push_back(rx_dbout);
		rx_fifo_full <= got.size() >= cap;
		neg_d <= {rxd[3:0], rxdv, rxer};
		eofd <= {eofd[2:0], rx_eof};
		rx_fifo_eof_read <= eofd[3];
	end
endmodule

// >>> sim/test_rx_mac_fifo_status_interface.sv
/*
 * Self-checking bench of the receive MAC: register bus master, frames in
 * every option, fifo overflow, interrupt and half-duplex inputs.
 * Assumes the far-side model and the design sources are compiled first.
 */
`timescale 1ns/10ps
`include "rxm_defines.svh"
module test_rx_mac_fifo_status_interface;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rxd, rx_dbout;
	logic [31:0] s_axi_wdata, s_axi_rdata, rx_stat_vector, vec;
	logic [3:0] s_axi_wstrb, rxd_pos, rxd_neg;
	logic [1:0] s_axi_bresp, s_axi_rresp, nz;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, rxdv, rxer, rxdv_pos, rxdv_neg, rxer_pos, rxer_neg, col, crs;
	logic rx_fifo_full, rx_fifo_eof_read, rx_write, rx_eof, rx_fifo_error, rx_stat_en, irq;
	int fail_count = 0, comparisons = 0, nvec = 0;
	int lens[6] = '{63, 64, 1518, 1519, 0, 0};

	rxm_top #(.IPG_MIN(2)) dut (.*);
	rxm_phy_model phy (.*);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		col <= nz[1] | (nz[0] & 1'($urandom));
		crs <= nz[1] | (nz[0] & 1'($urandom));
		if (rx_stat_en === 1'b1) begin
			vec <= rx_stat_vector;
			nvec <= nvec + 1;
		end
	end
	initial begin
		repeat (60000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	task final_report;
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(r));
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk(32'(s_axi_rresp), 32'(r));
	endtask
	function automatic logic [31:0] exp_vec(int n, logic [7:0] d0, logic bc, logic dr);
		exp_vec = 32'(n);
		exp_vec[21] = bc;
		exp_vec[22] = d0[0] & !bc;
		exp_vec[26] = dr;
		exp_vec[30] = n < 64;
		exp_vec[31] = n > 1518;
	endfunction
	// kind 0 unicast, 1 multicast, 2 broadcast; ng bytes expected in the fifo
	task automatic frame(input int n, kind, ng);
		logic [7:0] f[$];
		logic ok;
		for (int i = 0; i < n; i++) f.push_back(8'($urandom));
		for (int i = 0; i < 6; i++) if (kind == 2) f[i] = 8'hFF;
		f[0][0] = kind != 0;
		f[12] = 8'h08;
		f[13] = 8'h00;
		phy.got.delete();
		nvec = 0;
		phy.send(f);
		repeat (12 * phy.hold) @(posedge aclk);
		ok = 1'b1;
		foreach (phy.got[i]) if (phy.got[i] !== f[i]) ok = 1'b0;
		chk(32'(ok), 1);
		chk(32'(phy.got.size()), 32'(ng));
		chk(32'(nvec), 1);
		chk(vec & 32'hFD7FFFFF, exp_vec(n, f[0], kind == 2, ng != n));
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, nz} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(99469));
		lens[4] = 20 + $urandom % 200;
		lens[5] = 20 + $urandom % 200;
		nz <= 2'h1;
		rd(`RXM_ADDR_CTRL, 32'hFFFFFFFF, 32'h1, 2'h0);
		rd(8'h18, 32'hFFFFFFFF, 32'h0, 2'h2);
		wr(8'h18, 32'h0, 2'h2);
		// media error inside every frame exercises both error paths
		phy.err_at = 12;
		foreach (lens[k]) begin
			wr(`RXM_ADDR_CTRL, 32'(k % 3 * 2 + 1));
			frame(lens[k], k % 3, lens[k]);
		end
		chk(32'(irq), 0);
		rd(`RXM_ADDR_STATUS, 32'h3, 32'h0, 2'h0);
		wr(`RXM_ADDR_IRQ_EN, 32'h6);
		@(posedge aclk);
		chk(32'(irq), 1);
		wr(`RXM_ADDR_CTRL, 32'h0B);
		phy.hold = 2;
		frame(80, 1, 80);
		phy.hold = 1;
		wr(`RXM_ADDR_CTRL, 32'h03);
		phy.cap = 10;
		phy.got.delete();
		frame(40, 0, 10);
		phy.cap = 100000;
		repeat (20) @(posedge aclk);
		chk(32'(rx_fifo_error), 0);
		rd(`RXM_ADDR_IRQ_STAT, 32'hF, 32'h6, 2'h0);
		wr(`RXM_ADDR_IRQ_CLR, 32'hF);
		@(posedge aclk);
		chk(32'(irq), 0);
		nz <= 2'h2;
		wr(`RXM_ADDR_CTRL, 32'h19);
		repeat (4) @(posedge aclk);
		rd(`RXM_ADDR_STATUS, 32'h3, 32'h3, 2'h0);
		rd(`RXM_ADDR_IRQ_STAT, 32'h8, 32'h8, 2'h0);
		final_report();
	end
endmodule
